// ### oau_unit.sv
// module: operand addressing unit with pointer register page
`timescale 1ns/1ns
module oau_unit (
   input wire logic mclk, // core clock
   input wire logic sys_rst, // async reset, high
   input wire logic ce, // clock enable
   input wire logic start, // instruction issue pulse
   input wire oau_pkg::oau_op_t op, // instruction class
   input wire oau_pkg::oau_mode_t mode, // operand mode
   input wire logic ptrSel, // 0 selects B, 1 selects X
   input wire logic [7:0] opAddr, // address byte, register or short nibble
   input wire logic [2:0] bitSel, // bit number for bit operations
   output logic pmReq, // request next program byte
   input wire logic pmValid, // program byte valid
   input wire logic [7:0] pmData, // program byte
   output logic dmRd, // data memory read strobe
   output logic dmWr, // data memory write strobe
   output logic [7:0] dmAddr, // data memory address
   output logic [7:0] dmWdata, // data memory write data
   input wire logic [7:0] dmRdata, // read data, valid in the same cycle as dmRd
   output logic [7:0] acc, // accumulator
   output logic testResult, // last bit test result
   output logic done, // instruction finished pulse
   output logic illegal, // mode not allowed for class
   output logic busy, // operation in progress
   output logic [7:0] ptrB, // first pointer
   output logic [7:0] ptrX, // second pointer
   output logic [7:0] stack_pointer_register // stack pointer
);
   typedef enum logic [1:0] {ST_IDLE, ST_IMM, ST_READ} oau_state_t;

   oau_state_t state;
   oau_pkg::oau_op_t opL;
   oau_pkg::oau_mode_t modeL;
   logic selL;
   logic [2:0] bitL;
   logic [7:0] regs [oau_pkg::REG_COUNT];

   oau_pkg::oau_op_t curOp;
   oau_pkg::oau_mode_t curMode;
   logic curSel;
   logic [3:0] ptrIdx;
   logic [7:0] selPtr;
   logic [7:0] ea;
   logic regHit;
   logic legal;
   logic issue;
   logic execNow;
   logic [7:0] opnd;
   logic writes;
   logic postMod;

   oau_alu_if aluIf ();

   oau_alu u_alu (
      .aluIf(aluIf.alu)
   );

   // ==========================================================
   // operand selection
   assign curOp = (state == ST_IDLE) ? op : opL;
   assign curMode = (state == ST_IDLE) ? mode : modeL;
   assign curSel = (state == ST_IDLE) ? ptrSel : selL;
   // pointers live in the register page
   assign ptrIdx = curSel ? oau_pkg::IDX_X : oau_pkg::IDX_B;
   assign selPtr = regs[ptrIdx];

   always_comb begin
      unique case (mode)
         oau_pkg::MD_DIRECT: ea = opAddr;
         oau_pkg::MD_REG: ea = {oau_pkg::REG_PAGE, opAddr[3:0]};
         default: ea = selPtr;
      endcase
   end

   // load takes all modes, others a subset
   always_comb begin
      unique case (op)
         oau_pkg::OP_LOAD: legal = 1'b1;
         oau_pkg::OP_EXCH: legal = (mode != oau_pkg::MD_IMM);
         oau_pkg::OP_LDBS: legal = (mode == oau_pkg::MD_IMM);
         default: legal = (mode == oau_pkg::MD_DIRECT) || (mode == oau_pkg::MD_IND)
                          || (mode == oau_pkg::MD_REG);
      endcase
   end

   assign issue = ce && (state == ST_IDLE) && start && legal;
   assign regHit = (ea[7:4] == oau_pkg::REG_PAGE);
   // register page needs no bus cycle, so it completes at once
   assign execNow = (issue && op != oau_pkg::OP_LDBS && mode != oau_pkg::MD_IMM && regHit)
                    || (ce && state == ST_READ);
   assign opnd = (state == ST_READ) ? dmRdata : regs[ea[3:0]];
   assign writes = (curOp == oau_pkg::OP_EXCH) || (curOp == oau_pkg::OP_SETB)
                   || (curOp == oau_pkg::OP_CLRB);
   assign postMod = (curMode == oau_pkg::MD_INC) || (curMode == oau_pkg::MD_DEC);

   assign aluIf.data = opnd;
   assign aluIf.acc = acc;
   assign aluIf.op = curOp;
   assign aluIf.bitSel = (state == ST_IDLE) ? bitSel : bitL;
   assign aluIf.ptr = selPtr;
   assign aluIf.dec = (curMode == oau_pkg::MD_DEC);

   // ==========================================================
   // sequencing and bus strobes
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         opL <= oau_pkg::OP_LOAD;
         modeL <= oau_pkg::MD_DIRECT;
         selL <= 1'b0;
         bitL <= 3'h0;
         pmReq <= 1'b0;
         dmRd <= 1'b0;
         dmWr <= 1'b0;
         dmAddr <= 8'h00;
         dmWdata <= 8'h00;
         done <= 1'b0;
         illegal <= 1'b0;
         busy <= 1'b0;
      end else if (ce) begin
         pmReq <= 1'b0;
         dmRd <= 1'b0;
         dmWr <= 1'b0;
         done <= 1'b0;
         illegal <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  opL <= op;
                  modeL <= mode;
                  selL <= ptrSel;
                  bitL <= bitSel;
                  if (!legal) begin
                     illegal <= 1'b1;
                     done <= 1'b1;
                  end else if (op == oau_pkg::OP_LDBS) begin
                     done <= 1'b1;
                  end else if (mode == oau_pkg::MD_IMM) begin
                     // fetch data byte from program memory
                     pmReq <= 1'b1;
                     busy <= 1'b1;
                     state <= ST_IMM;
                  end else if (regHit) begin
                     done <= 1'b1;
                  end else begin
                     dmRd <= 1'b1;
                     dmAddr <= ea;
                     busy <= 1'b1;
                     state <= ST_READ;
                  end
               end
            end
            ST_IMM: begin
               if (pmValid) begin
                  done <= 1'b1;
                  busy <= 1'b0;
                  state <= ST_IDLE;
               end
            end
            ST_READ: begin
               // write back on the same address
               if (writes) begin
                  dmWr <= 1'b1;
                  dmWdata <= aluIf.memResult;
               end
               done <= 1'b1;
               busy <= 1'b0;
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // ==========================================================
   // accumulator and test flag
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         acc <= oau_pkg::ACC_RESET;
         testResult <= 1'b0;
      end else if (ce) begin
         if (state == ST_IMM && pmValid) begin
            acc <= pmData;
         end else if (execNow && (curOp == oau_pkg::OP_LOAD || curOp == oau_pkg::OP_EXCH)) begin
            acc <= opnd;
         end
         if (execNow && curOp == oau_pkg::OP_TSTB) begin
            testResult <= aluIf.testBit;
         end
      end
   end

   // ==========================================================
   // register page, pointer update last so it wins a clash
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < oau_pkg::REG_COUNT; i++) begin
            regs[i] <= oau_pkg::REG_RESET;
         end
      end else if (ce) begin
         if (execNow && state == ST_IDLE && writes) begin
            regs[ea[3:0]] <= aluIf.memResult;
         end
         if (issue && op == oau_pkg::OP_LDBS) begin
            regs[oau_pkg::IDX_B] <= {oau_pkg::SHORT_UPPER, opAddr[3:0]};
         end
         if (execNow && postMod) begin
            regs[ptrIdx] <= aluIf.ptrNext;
         end
      end
   end

   assign ptrB = regs[oau_pkg::IDX_B];
   assign ptrX = regs[oau_pkg::IDX_X];
   assign stack_pointer_register = regs[oau_pkg::IDX_STACK];

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst || !ce);

   AST_DIRECT_ADDR: assert property (
      issue && op == oau_pkg::OP_LOAD && mode == oau_pkg::MD_DIRECT && opAddr[7:4] != 4'hf
      |=> dmRd && dmAddr == $past(opAddr) ##1 done)
      else $error("direct address not taken from instruction");
   AST_IND_ADDR: assert property (
      issue && mode == oau_pkg::MD_IND && !regHit |=> dmRd && dmAddr == $past(selPtr))
      else $error("indirect address not taken from pointer");
   AST_POST_INC: assert property (
      state == ST_READ && modeL == oau_pkg::MD_INC
      |=> (selL ? ptrX : ptrB) == $past(selPtr) + 8'h01)
      else $error("pointer not incremented after access");
   AST_IMM_FETCH: assert property (
      issue && mode == oau_pkg::MD_IMM && op == oau_pkg::OP_LOAD
      |=> pmReq && !dmRd ##1 (state == ST_IMM || done))
      else $error("immediate fetch not requested");
   AST_LDB_SHORT: assert property (
      issue && op == oau_pkg::OP_LDBS |=> ptrB == {4'h0, $past(opAddr[3:0])} && done)
      else $error("short load of first pointer wrong");
   AST_EXCH_SWAP: assert property (
      state == ST_READ && opL == oau_pkg::OP_EXCH
      |=> dmWr && dmWdata == $past(acc) && acc == $past(dmRdata))
      else $error("exchange did not swap");
   AST_PTR_KEPT: assert property (
      state == ST_READ && modeL == oau_pkg::MD_IND |=> $stable(ptrB) && $stable(ptrX))
      else $error("pointer changed without post-modify");
   AST_ONE_CYCLE: assert property (
      execNow && state == ST_IDLE |=> done && !busy)
      else $error("register page operation not single cycle");
   AST_SET_BIT: assert property (
      state == ST_READ && opL == oau_pkg::OP_SETB
      |=> dmWr && dmWdata == ($past(dmRdata) | (8'h01 << $past(bitL))))
      else $error("set bit wrote wrong value");
   AST_ILLEGAL: assert property (
      ce && state == ST_IDLE && start && op == oau_pkg::OP_EXCH && mode == oau_pkg::MD_IMM
      |=> illegal && done && !dmRd && !pmReq)
      else $error("illegal mode not refused");
   AST_DEC_WRAP: assert property (
      execNow && curMode == oau_pkg::MD_DEC && selPtr == 8'h00
      |=> (selL ? ptrX : ptrB) == 8'hff)
      else $error("decrement did not wrap");
   AST_POST_DEC: assert property (
      state == ST_READ && modeL == oau_pkg::MD_DEC
      |=> (selL ? ptrX : ptrB) == $past(selPtr) - 8'h01)
      else $error("pointer not decremented after access");
   AST_IMM_DATA: assert property (
      state == ST_IMM && pmValid |=> acc == $past(pmData) && done && !busy)
      else $error("immediate byte not loaded");
   AST_CLR_BIT: assert property (
      state == ST_READ && opL == oau_pkg::OP_CLRB
      |=> dmWr && dmWdata == ($past(dmRdata) & ~(8'h01 << $past(bitL))))
      else $error("clear bit wrote wrong value");
   AST_NO_PAGE_BUS: assert property (
      dmRd || dmWr |-> dmAddr[7:4] != oau_pkg::REG_PAGE)
      else $error("register page address reached the bus");
   // freeze only shows with ce low, so this one keeps just the reset disable
   AST_CE_FREEZE: assert property (@(posedge mclk) disable iff (sys_rst)
      !ce |=> $stable(acc) && $stable(ptrB) && $stable(ptrX)
      && $stable(done) && $stable(state))
      else $error("state moved while clock enable low");

   COV_EXCH_INC: cover property (issue && op == oau_pkg::OP_EXCH && mode == oau_pkg::MD_INC);
   COV_IMM_LOAD: cover property (state == ST_IMM && pmValid);
   COV_BIT_TEST: cover property (execNow && curOp == oau_pkg::OP_TSTB);
   COV_LDB_SHORT: cover property (issue && op == oau_pkg::OP_LDBS);
endmodule : oau_unit

// ### oau_pkg.sv
// package: shared types and constants of the operand addressing unit
package oau_pkg;
   // ==========================================================
   // instruction classes and operand modes
   typedef enum logic [2:0] {
      OP_LOAD,
      OP_EXCH,
      OP_SETB,
      OP_CLRB,
      OP_TSTB,
      OP_LDBS
   } oau_op_t;

   typedef enum logic [2:0] {
      MD_DIRECT,
      MD_IND,
      MD_INC,
      MD_DEC,
      MD_IMM,
      MD_REG
   } oau_mode_t;

   // ==========================================================
   // register page mapping
   localparam logic [3:0] REG_PAGE = 4'hf;
   localparam logic [3:0] IDX_X = 4'hc;
   localparam logic [3:0] IDX_STACK = 4'hd;
   localparam logic [3:0] IDX_B = 4'he;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [3:0] SHORT_UPPER = 4'h0;
   localparam logic [7:0] PTR_STEP = 8'h01;
   localparam int REG_COUNT = 16;
endpackage : oau_pkg

// ### oau_alu_if.sv
// interface: operand data path between sequencer and operand ALU
`timescale 1ns/1ns
interface oau_alu_if;
   logic [7:0] data;
   logic [7:0] acc;
   oau_pkg::oau_op_t op;
   logic [2:0] bitSel;
   logic [7:0] ptr;
   logic dec;
   logic [7:0] memResult;
   logic testBit;
   logic [7:0] ptrNext;

   modport ctrl (output data, acc, op, bitSel, ptr, dec, input memResult, testBit, ptrNext);
   modport alu (input data, acc, op, bitSel, ptr, dec, output memResult, testBit, ptrNext);
endinterface : oau_alu_if

// ### oau_alu.sv
// module: bit manipulation, exchange data and pointer stepping
`timescale 1ns/1ns
module oau_alu (
   oau_alu_if.alu aluIf // operand path
);
   logic [7:0] mask;

   assign mask = 8'h01 << aluIf.bitSel;

   // ==========================================================
   // memory write-back value
   always_comb begin
      unique case (aluIf.op)
         oau_pkg::OP_EXCH: aluIf.memResult = aluIf.acc;
         oau_pkg::OP_SETB: aluIf.memResult = aluIf.data | mask;
         oau_pkg::OP_CLRB: aluIf.memResult = aluIf.data & ~mask;
         default: aluIf.memResult = aluIf.data;
      endcase
   end

   assign aluIf.testBit = |(aluIf.data & mask);

   // wraps modulo 256, no carry out
   assign aluIf.ptrNext = aluIf.dec ? aluIf.ptr - oau_pkg::PTR_STEP
                                    : aluIf.ptr + oau_pkg::PTR_STEP;
endmodule : oau_alu

// ### oau_mem_model.sv
// data memory and program byte source facing the operand unit
`timescale 1ns/1ns
// ==========================================
// memory and fetch model
module oau_mem_model (
   input wire logic mclk, // core clock
   input wire logic sys_rst, // async reset
   input wire logic pmReq, // byte request
   output logic pmValid, // byte valid
   output logic [7:0] pmData, // program byte
   input wire logic [2:0] pmDelay, // answer delay, 1 or more
   input wire logic [7:0] immByte, // byte to hand over
   input wire logic dmRd, // read strobe
   input wire logic dmWr, // write strobe
   input wire logic [7:0] dmAddr, // address
   input wire logic [7:0] dmWdata, // write data
   output logic [7:0] dmRdata // read data
);
   logic [7:0] mem [256];
   logic [2:0] cnt;
   // read data answers within the strobe cycle; off strobe it shows the inverse
   assign dmRdata = dmRd ? mem[dmAddr] : ~mem[dmAddr];
   initial begin
      for (int i = 0; i < 256; i++) begin
         mem[i] = i[7:0] ^ 8'h5a;
      end
   end
   // stale lines inverted every cycle so old data never looks valid
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         pmValid <= 1'b0;
         pmData <= 8'h00;
         cnt <= 3'h0;
      end else begin
         pmValid <= 1'b0;
         pmData <= ~pmData;
         if (dmWr) begin
            mem[dmAddr] <= dmWdata;
         end
         if (pmReq) begin
            cnt <= pmDelay;
         end else if (cnt != 3'h0) begin
            cnt <= cnt - 3'h1;
            pmValid <= cnt == 3'h1;
            pmData <= (cnt == 3'h1) ? immByte : ~pmData;
         end
      end
   end
endmodule : oau_mem_model

// ### tb_top.sv
// self-checking bench for the operand addressing unit
`timescale 1ns/1ns
module tb_top;
   logic mclk, sys_rst, ce, start, ptrSel, pmReq, pmValid, dmRd, dmWr;
   logic testResult, done, illegal, busy, mTest;
   oau_pkg::oau_op_t op;
   oau_pkg::oau_mode_t mode;
   logic [7:0] opAddr, pmData, dmAddr, dmWdata, dmRdata, acc, ptrB, ptrX, stackPtr;
   logic [7:0] immByte, mAcc;
   logic [2:0] bitSel, pmDelay;
   logic [7:0] shadow [256];
   logic [7:0] regs [16];
   int failures, checks, cycles, seed, r;
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   oau_unit i_oau_unit (.mclk(mclk), .sys_rst(sys_rst), .ce(ce), .start(start), .op(op),
      .mode(mode), .ptrSel(ptrSel), .opAddr(opAddr), .bitSel(bitSel), .pmReq(pmReq),
      .pmValid(pmValid), .pmData(pmData), .dmRd(dmRd), .dmWr(dmWr), .dmAddr(dmAddr),
      .dmWdata(dmWdata), .dmRdata(dmRdata), .acc(acc), .testResult(testResult),
      .done(done), .illegal(illegal), .busy(busy), .ptrB(ptrB), .ptrX(ptrX),
      .stack_pointer_register(stackPtr));
   oau_mem_model i_oau_mem_model (.mclk(mclk), .sys_rst(sys_rst), .pmReq(pmReq),
      .pmValid(pmValid), .pmData(pmData), .pmDelay(pmDelay), .immByte(immByte),
      .dmRd(dmRd), .dmWr(dmWr), .dmAddr(dmAddr), .dmWdata(dmWdata), .dmRdata(dmRdata));
   // ==========================================
   // checking and closing
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic summarize();
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : summarize
   // op codes: 0 load, 1 exchange, 2 set, 3 clear, 4 test, 5 short load
   function automatic logic legalOp(input int o, input int m);
      if (o == 5) return m == 4;
      if (m == 4) return o == 0;
      if (m == 2 || m == 3) return o < 2;
      return 1'b1;
   endfunction : legalOp
   // ==========================================
   // one instruction with prediction
   task automatic run(input int o, input int m, input logic s, input logic [7:0] a,
         input logic [2:0] b);
      logic [7:0] ea, old, wv, iv, pv;
      logic lg, pg, wr;
      int ix, el, lat;
      lg = legalOp(o, m);
      ix = s ? 12 : 14;
      ea = (m == 0) ? a : (m == 5) ? {4'hf, a[3:0]} : regs[ix];
      pg = ea[7:4] == 4'hf;
      old = pg ? regs[ea[3:0]] : shadow[ea];
      iv = $random(seed);
      wr = 1'b0;
      wv = old;
      pv = (m == 2) ? regs[ix] + 8'h01 : regs[ix] - 8'h01;
      el = (!lg || o == 5 || pg) ? 1 : 2;
      if (lg) begin
         case (o)
            0: mAcc = (m == 4) ? iv : old;
            1: begin
               wv = mAcc;
               mAcc = old;
               wr = 1'b1;
            end
            2: {wr, wv} = {1'b1, old | (8'h01 << b)};
            3: {wr, wv} = {1'b1, old & ~(8'h01 << b)};
            4: mTest = old[b];
            default: regs[14] = {4'h0, a[3:0]};
         endcase
         if (wr && pg) regs[ea[3:0]] = wv;
         if (wr && !pg) shadow[ea] = wv;
         // post-modify value wins over write-back
         if (m == 2 || m == 3) regs[ix] = pv;
      end
      @(posedge mclk);
      start <= 1'b1;
      op <= oau_pkg::oau_op_t'(o);
      mode <= oau_pkg::oau_mode_t'(m);
      ptrSel <= s;
      opAddr <= a;
      bitSel <= b;
      immByte <= iv;
      pmDelay <= 3'(iv % 8'd7 + 8'd1);
      lat = 0;
      do begin
         @(posedge mclk);
         start <= 1'b0;
         #1;
         lat++;
      end while (done !== 1'b1 && lat < 20);
      if (!(lg && m == 4 && o == 0)) chk("latency", 8'(el), 8'(lat)); // fixed timing
      chk("busy", 8'h00, {7'h0, busy}); // idle at completion
      chk("illegal", {7'h0, !lg}, {7'h0, illegal}); // mode subset
      chk("acc", mAcc, acc); // operand value
      chk("ptrB", regs[14], ptrB); // first pointer
      chk("ptrX", regs[12], ptrX); // second pointer
      chk("stackPtr", regs[13], stackPtr); // stack pointer
      chk("testResult", {7'h0, mTest}, {7'h0, testResult}); // bit test
      // write strobe leaves with done, the memory takes it one edge later
      @(posedge mclk);
      #1;
      chk("memory", shadow[ea], i_oau_mem_model.mem[ea]); // write back
   endtask : run
   // ==========================================
   // watchdogs
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 8000) begin
         failures++;
         summarize();
      end
   end
   always @(negedge mclk) begin
      if ((dmRd | dmWr) === 1'b1) begin
         chk("busPage", 8'h00, {7'h0, dmAddr[7:4] == 4'hf}); // page stays inside
      end
   end
   // ==========================================
   // main sequence
   initial begin
      seed = 32'h1ee89579;
      {sys_rst, ce, start, ptrSel, mTest} = 5'b11000;
      op = oau_pkg::OP_LOAD;
      mode = oau_pkg::MD_DIRECT;
      {opAddr, bitSel, immByte, pmDelay, mAcc} = {8'h00, 3'h0, 8'h00, 3'h1, 8'h00};
      {failures, checks, cycles} = {32'd0, 32'd0, 32'd0};
      for (int i = 0; i < 256; i++) shadow[i] = i[7:0] ^ 8'h5a;
      for (int i = 0; i < 16; i++) regs[i] = 8'h00;
      repeat (4) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int m = 0; m < 6; m++) run(0, m, m[0], 8'h23, 3'h0);
      run(5, 4, 0, 8'ha7, 3'h0);
      // wrap both ways: acc ff into first pointer
      run(0, 0, 0, 8'ha5, 3'h0);
      run(1, 5, 0, 8'h0e, 3'h0);
      run(0, 2, 0, 8'h00, 3'h0);
      run(0, 3, 0, 8'h00, 3'h0);
      run(1, 5, 0, 8'h0c, 3'h0);
      run(1, 1, 1, 8'h00, 3'h0);
      run(5, 0, 0, 8'h12, 3'h0);
      run(4, 2, 0, 8'h12, 3'h1);
      run(1, 4, 1, 8'h12, 3'h0);
      // frozen clock enable: a pending short load must not land
      @(posedge mclk);
      ce <= 1'b0;
      start <= 1'b1;
      op <= oau_pkg::OP_LDBS;
      mode <= oau_pkg::MD_IMM;
      opAddr <= 8'h09;
      repeat (3) @(posedge mclk);
      #1;
      chk("frozenPtrB", regs[14], ptrB); // held while frozen
      chk("frozenDone", 8'h00, {7'h0, done}); // no completion while frozen
      @(posedge mclk);
      ce <= 1'b1;
      start <= 1'b0;
      // mid-run reset clears the register page and accumulator
      @(posedge mclk);
      sys_rst <= 1'b1;
      @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 16; i++) regs[i] = 8'h00;
      {mAcc, mTest} = 9'h000;
      run(0, 5, 0, 8'h0d, 3'h0); // page cleared by reset
      // every bit, memory and register page
      for (int b = 0; b < 8; b++) begin
         run(2, 0, 0, 8'h40, b[2:0]);
         run(4, 0, 0, 8'h40, b[2:0]);
         run(3, 5, 0, 8'h03, b[2:0]);
         run(4, 5, 0, 8'h03, b[2:0]);
      end
      repeat (300) begin
         r = $random(seed);
         run(r[2:0] % 3'd6, r[5:3] % 3'd6, r[6], r[15:8], r[18:16]);
      end
      summarize();
   end
endmodule : tb_top
